// *** verilog/dwpm_top.sv ***
// Write-port input logic: select, two-beat data capture and lane masking
`timescale 1ns/1ps
module dwpm_top
  import dwpm_pkg::*;
#(
  parameter int DATA_W = DWPM_DATA_W_DEF,
  parameter int ADDR_W = DWPM_ADDR_W_DEF
)
(
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic WR_CLK_IN,
  input wire logic WR_CLK_N_IN,
  input wire logic WRITE_PORT_SELECT_N_IN,
  input wire logic [DWPM_NIBBLE_MASK_W-1:0] NIBBLE_WRITE_MASK_N_IN,
  input wire logic [DWPM_BYTE_MASK_W-1:0] BYTE_WRITE_MASK_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic [ADDR_W:0] RD_WORD_ADDR_IN,
  output logic [DATA_W-1:0] RD_DATA_OUT,
  output logic WR_DONE_OUT,
  output logic [ADDR_W-1:0] WR_ADDR_OUT,
  output logic BUSY_OUT
);

  // ----------------------------------------------------------------------
  // Lane geometry
  // ----------------------------------------------------------------------
  localparam bit NIBBLE_MODE = (DATA_W == DWPM_NIBBLE_VARIANT_W);
  localparam int LANE_W = NIBBLE_MODE ? DWPM_NIBBLE_W : DWPM_BYTE_W;
  localparam int SYNC_W = DWPM_CTRL_W + ADDR_W + DATA_W;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  // Lane enables, one bit per data bit, from active-low lane masks
  function automatic logic [DATA_W-1:0] lane_enable(
    input logic [DWPM_BYTE_MASK_W-1:0] mask_n);
    logic [DATA_W-1:0] en;
    en = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      en[i] = ~mask_n[i / LANE_W]; // [RULE7]
    end
    return en;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  // K and K# are oversampled; the whole bundle shares one delay, so each
  // beat stays aligned with the edge that qualifies it.
  logic [SYNC_W-1:0] pins_s;
  logic k_s;
  logic kn_s;
  logic wps_n_s;
  logic [DWPM_NIBBLE_MASK_W-1:0] nib_n_s;
  logic [DWPM_BYTE_MASK_W-1:0] byte_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [DWPM_BYTE_MASK_W-1:0] mask_n_s;

  dwpm_sync #(.W(SYNC_W)) u_sync (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in({WR_CLK_IN, WR_CLK_N_IN, WRITE_PORT_SELECT_N_IN,
      NIBBLE_WRITE_MASK_N_IN, BYTE_WRITE_MASK_N_IN, ADDR_IN, DATA_IN}),
    .sync_out(pins_s)
  );

  assign {k_s, kn_s, wps_n_s, nib_n_s, byte_n_s, addr_s, data_s} = pins_s;

  // Nibble masks on the 8-bit variant, byte masks otherwise
  assign mask_n_s = NIBBLE_MODE
    ? {{(DWPM_BYTE_MASK_W - DWPM_NIBBLE_MASK_W){1'b1}}, nib_n_s} // [RULE4]
    : byte_n_s; // [RULE6]

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  logic k_last_q;
  logic k_last_d;
  logic kn_last_q;
  logic kn_last_d;
  logic k_rise;
  logic kn_rise;

  assign k_rise = k_s & ~k_last_q;
  assign kn_rise = kn_s & ~kn_last_q;

  // ----------------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------------
  dwpm_state_t state_q;
  dwpm_state_t state_d;
  logic [DATA_W-1:0] beat0_q;
  logic [DATA_W-1:0] beat0_d;
  logic [DATA_W-1:0] beat1_q;
  logic [DATA_W-1:0] beat1_d;
  logic [DATA_W-1:0] en0_q;
  logic [DATA_W-1:0] en0_d;
  logic [DATA_W-1:0] en1_q;
  logic [DATA_W-1:0] en1_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic done_q;
  logic done_d;
  logic busy_q;
  logic busy_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic mem_we;
  logic [ADDR_W:0] mem_addr;
  logic [DATA_W-1:0] mem_new;
  logic [DATA_W-1:0] mem_en;

  always_comb
  begin
    state_d = state_q;
    beat0_d = beat0_q;
    beat1_d = beat1_q;
    en0_d = en0_q;
    en1_d = en1_q;
    addr_d = addr_q;
    done_d = 1'b0;
    k_last_d = k_s;
    kn_last_d = kn_s;
    mem_we = 1'b0;
    mem_addr = {addr_q, DWPM_BEAT_SECOND};
    mem_new = beat1_q;
    mem_en = en1_q;
    case (state_q)
      DWPM_ST_IDLE:
      begin
        // Deselected cycles leave every capture register untouched
        if (k_rise && !wps_n_s) // [RULE2] [RULE3]
        begin
          beat0_d = data_s; // [RULE1]
          en0_d = lane_enable(mask_n_s); // [RULE8]
          state_d = DWPM_ST_WAIT_KN;
        end
      end
      DWPM_ST_WAIT_KN:
      begin
        if (kn_rise)
        begin
          addr_d = addr_s; // [RULE10]
          beat1_d = data_s; // [RULE1]
          en1_d = lane_enable(mask_n_s); // [RULE8]
          mem_we = 1'b1;
          mem_addr = {addr_s, DWPM_BEAT_FIRST}; // [RULE11]
          mem_new = beat0_q;
          mem_en = en0_q;
          state_d = DWPM_ST_COMMIT1;
        end
        else if (k_rise && wps_n_s)
        begin
          // Clock restarted with the port deselected: drop the beat
          state_d = DWPM_ST_IDLE;
        end
      end
      DWPM_ST_COMMIT1:
      begin
        mem_we = 1'b1; // [RULE11]
        done_d = 1'b1;
        state_d = DWPM_ST_IDLE;
      end
      default:
      begin
        state_d = DWPM_ST_IDLE;
      end
    endcase
    busy_d = (state_d != DWPM_ST_IDLE);
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q <= DWPM_ST_IDLE;
      beat0_q <= '0;
      beat1_q <= '0;
      en0_q <= '0;
      en1_q <= '0;
      addr_q <= '0;
      done_q <= 1'b0;
      k_last_q <= 1'b0;
      kn_last_q <= 1'b0;
      busy_q <= 1'b0;
      rd_data_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      beat0_q <= beat0_d;
      beat1_q <= beat1_d;
      en0_q <= en0_d;
      en1_q <= en1_d;
      addr_q <= addr_d;
      done_q <= done_d;
      k_last_q <= k_last_d;
      kn_last_q <= kn_last_d;
      busy_q <= busy_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------------
  // Array with masked read-modify-write
  // ----------------------------------------------------------------------
  // Merge is done on the full word so one write port serves every mask;
  // the cost is a read of the old word in the same cycle.
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] mem_old;
  logic [DATA_W-1:0] mem_merged;

  always_comb
  begin
    mem_old = mem[mem_addr];
    mem_merged = (mem_old & ~mem_en) | (mem_new & mem_en); // [RULE5] [RULE9]
    rd_data_d = mem[RD_WORD_ADDR_IN];
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (mem_we)
    begin
      mem[mem_addr] <= mem_merged;
    end
  end

  assign RD_DATA_OUT = rd_data_q;
  assign WR_DONE_OUT = done_q;
  assign WR_ADDR_OUT = addr_q;
  assign BUSY_OUT = busy_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_deselect_ignored;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_IDLE && k_rise && wps_n_s)
      |=> (state_q == DWPM_ST_IDLE) && $stable(beat0_q) && !done_q;
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored) // [RULE3]
    else $error("deselected write was not ignored");

  property p_select_starts;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_IDLE && k_rise && !wps_n_s)
      |=> state_q == DWPM_ST_WAIT_KN;
  endproperty
  a_select_starts: assert property (p_select_starts) // [RULE2]
    else $error("selected write did not start");

  property p_beat0_capture;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_IDLE && k_rise && !wps_n_s)
      |=> beat0_q == $past(data_s) && en0_q == lane_enable($past(mask_n_s));
  endproperty
  a_beat0_capture: assert property (p_beat0_capture) // [RULE1]
    else $error("first beat or its mask not captured");

  property p_beat1_capture;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_WAIT_KN && kn_rise)
      |=> beat1_q == $past(data_s) && en1_q == lane_enable($past(mask_n_s));
  endproperty
  a_beat1_capture: assert property (p_beat1_capture) // [RULE8]
    else $error("second beat or its mask not captured");

  property p_addr_capture;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_WAIT_KN && kn_rise) |=> addr_q == $past(addr_s);
  endproperty
  a_addr_capture: assert property (p_addr_capture) // [RULE10]
    else $error("write address not captured at second edge");

  property p_two_words;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_q == DWPM_ST_WAIT_KN && kn_rise)
      |=> mem_we && mem_addr[0] == DWPM_BEAT_SECOND ##1 done_q;
  endproperty
  a_two_words: assert property (p_two_words) // [RULE11]
    else $error("second word not written after first");

  property p_masked_kept;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mem_we |=> ((mem[$past(mem_addr)] ^ $past(mem_old))
      & ~$past(mem_en)) == '0;
  endproperty
  a_masked_kept: assert property (p_masked_kept) // [RULE5] [RULE9]
    else $error("masked lane was altered");

  property p_enabled_written;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mem_we |=> ((mem[$past(mem_addr)] ^ $past(mem_new)) & $past(mem_en)) == '0;
  endproperty
  a_enabled_written: assert property (p_enabled_written) // [RULE4] [RULE6]
    else $error("enabled lane not written");

endmodule

// *** verilog/dwpm_pkg.sv ***
// Constants shared by the DDR write-port masking block
// Behaviour
// (RULE1) Data is captured at both main and complementary clock rising edges.
// (RULE2) Low write port select at main clock rise starts a write.
// (RULE3) Select high deselects the port: data ignored, nothing stored.
// (RULE4) 8-bit variant: two low-active nibble masks per beat gate nibbles.
// (RULE5) A nibble with its mask deasserted keeps its stored value.
// (RULE6) Wider variants: low-active byte masks per beat gate 9-bit bytes.
// (RULE7) Mask 0 covers bits 8:0, 1 bits 17:9, 2 bits 26:18, 3 bits 35:27.
// (RULE8) Each mask is sampled on the same edge as the data beat it qualifies.
// (RULE9) A masked-off byte is ignored; the stored byte stays unaltered.
// (RULE10) Write address taken at complementary clock rise, unless deselected.
// (RULE11) The two beats go to the two consecutive words of the write address.
package dwpm_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int DWPM_DATA_W_DEF = 36;
  localparam int DWPM_ADDR_W_DEF = 20;
  localparam int DWPM_NIBBLE_VARIANT_W = 8;
  localparam int DWPM_NIBBLE_W = 4;
  localparam int DWPM_BYTE_W = 9;
  localparam int DWPM_NIBBLE_MASK_W = 2;
  localparam int DWPM_BYTE_MASK_W = 4;
  localparam logic DWPM_BEAT_FIRST = 1'b0;
  localparam logic DWPM_BEAT_SECOND = 1'b1;

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  localparam int DWPM_SYNC_STAGES = 2;
  localparam int DWPM_CTRL_W = 3 + DWPM_NIBBLE_MASK_W + DWPM_BYTE_MASK_W;

  // ----------------------------------------------------------------------
  // Write sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DWPM_ST_IDLE = 2'b00,
    DWPM_ST_WAIT_KN = 2'b01,
    DWPM_ST_COMMIT1 = 2'b10
  } dwpm_state_t;

endpackage

// *** verilog/dwpm_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module dwpm_sync
  import dwpm_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** testbench/dwpm_ctl_model.sv ***
// Memory controller model driving the write-port pins
`timescale 1ns/1ps
module dwpm_ctl_model
  import dwpm_pkg::*;
(
  input wire logic clk_in,
  output logic k_out,
  output logic kn_out,
  output logic sel_n_out,
  output logic [DWPM_NIBBLE_MASK_W-1:0] nib_n_out,
  output logic [DWPM_BYTE_MASK_W-1:0] byte_n_out,
  output logic [3:0] addr_out,
  output logic [35:0] data_out
);
  initial
  begin
    k_out = 1'b0;
    kn_out = 1'b0;
    sel_n_out = 1'b1;
    nib_n_out = 2'h3;
    byte_n_out = 4'hF;
    addr_out = 4'h0;
    data_out = 36'h0;
  end

  // Each K and K# high level is held three cycles so the synchronised pins see every edge
  task automatic burst(input logic sel_n, input logic [3:0] a,
    input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] b0,
    input logic [3:0] b1, input logic [1:0] n0, input logic [1:0] n1);
    @(posedge clk_in);
    sel_n_out <= sel_n;
    data_out <= d0;
    byte_n_out <= b0;
    nib_n_out <= n0;
    k_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    k_out <= 1'b0;
    sel_n_out <= 1'b1;
    addr_out <= a;
    data_out <= d1;
    byte_n_out <= b1;
    nib_n_out <= n1;
    repeat (2) @(posedge clk_in);
    kn_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    kn_out <= 1'b0;
    // Released lines flip so a stale beat can never pass for a good one
    addr_out <= ~a;
    data_out <= ~d1;
    byte_n_out <= ~b1;
    nib_n_out <= ~n1;
  endtask

  // Start a write, then raise K again deselected before K# comes
  task automatic cut_burst(input logic [3:0] a, input logic [35:0] d);
    @(posedge clk_in);
    sel_n_out <= 1'b0;
    data_out <= d;
    byte_n_out <= 4'h0;
    nib_n_out <= 2'h0;
    k_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    k_out <= 1'b0;
    sel_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    k_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    k_out <= 1'b0;
    addr_out <= a;
    repeat (3) @(posedge clk_in);
    kn_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    kn_out <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
    byte_n_out <= 4'hF;
    nib_n_out <= 2'h3;
  endtask
endmodule

// *** testbench/testbench.sv ***
// Bench for the write-port masking block, 36-bit and 8-bit variants
`timescale 1ns/1ps
module testbench
  import dwpm_pkg::*;
;
  logic mclk;
  logic sys_rst;
  logic k;
  logic kn;
  logic sel_n;
  logic [1:0] nib_n;
  logic [3:0] byte_n;
  logic [3:0] addr;
  logic [35:0] data;
  logic [4:0] rd_addr;
  logic [35:0] rd36;
  logic [7:0] rd8;
  logic done36;
  logic done8;
  logic [3:0] waddr36;
  logic [3:0] waddr8;
  logic busy36;
  logic busy8;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [35:0] exp36 [32];
  logic [7:0] exp8 [32];

  dwpm_ctl_model ctl_u (.clk_in(mclk), .k_out(k), .kn_out(kn),
    .sel_n_out(sel_n), .nib_n_out(nib_n), .byte_n_out(byte_n),
    .addr_out(addr), .data_out(data));
  dwpm_top #(.DATA_W(36), .ADDR_W(4)) dut_u (.MCLK_IN(mclk),
    .SYS_RST_IN(sys_rst), .WR_CLK_IN(k), .WR_CLK_N_IN(kn),
    .WRITE_PORT_SELECT_N_IN(sel_n), .NIBBLE_WRITE_MASK_N_IN(nib_n),
    .BYTE_WRITE_MASK_N_IN(byte_n), .ADDR_IN(addr), .DATA_IN(data),
    .RD_WORD_ADDR_IN(rd_addr), .RD_DATA_OUT(rd36), .WR_DONE_OUT(done36),
    .WR_ADDR_OUT(waddr36), .BUSY_OUT(busy36));
  dwpm_top #(.DATA_W(8), .ADDR_W(4)) dut8_u (.MCLK_IN(mclk),
    .SYS_RST_IN(sys_rst), .WR_CLK_IN(k), .WR_CLK_N_IN(kn),
    .WRITE_PORT_SELECT_N_IN(sel_n), .NIBBLE_WRITE_MASK_N_IN(nib_n),
    .BYTE_WRITE_MASK_N_IN(byte_n), .ADDR_IN(addr), .DATA_IN(data[7:0]),
    .RD_WORD_ADDR_IN(rd_addr), .RD_DATA_OUT(rd8), .WR_DONE_OUT(done8),
    .WR_ADDR_OUT(waddr8), .BUSY_OUT(busy8));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [35:0] e,
    input logic [35:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [35:0] mrg36(logic [35:0] o, logic [35:0] d,
    logic [3:0] m);
    logic [35:0] r;
    r = o;
    for (int l = 0; l < 4; l++)
      if (!m[l]) r[DWPM_BYTE_W*l +: DWPM_BYTE_W] = d[DWPM_BYTE_W*l +: 9];
    return r;
  endfunction

  function automatic logic [7:0] mrg8(logic [7:0] o, logic [7:0] d,
    logic [1:0] m);
    logic [7:0] r;
    r = o;
    for (int l = 0; l < 2; l++)
      if (!m[l]) r[4*l +: 4] = d[4*l +: 4];
    return r;
  endfunction

  // -------------
  // Bus cycles
  // -------------
  task automatic rd_both(input logic [3:0] a);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge mclk);
      rd_addr <= {a, b[0]};
      @(posedge mclk);
      #1;
      cmp("word36", exp36[{a, b[0]}], rd36);
      cmp("word8", {28'h0, exp8[{a, b[0]}]}, {28'h0, rd8});
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [35:0] d0,
    input logic [35:0] d1, input logic [3:0] b0, input logic [3:0] b1,
    input logic [1:0] n0, input logic [1:0] n1);
    int i;
    ctl_u.burst(1'b0, a, d0, d1, b0, b1, n0, n1);
    exp36[{a, 1'b0}] = mrg36(exp36[{a, 1'b0}], d0, b0);
    exp36[{a, 1'b1}] = mrg36(exp36[{a, 1'b1}], d1, b1);
    exp8[{a, 1'b0}] = mrg8(exp8[{a, 1'b0}], d0[7:0], n0);
    exp8[{a, 1'b1}] = mrg8(exp8[{a, 1'b1}], d1[7:0], n1);
    #1;
    cmp("busy36_on", 36'h1, {35'h0, busy36});
    cmp("busy8_on", 36'h1, {35'h0, busy8});
    i = 0;
    do
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    while (done36 !== 1'b1 && i < 20);
    cmp("done36", 36'h1, {35'h0, done36});
    cmp("done8", 36'h1, {35'h0, done8});
    cmp("waddr36", {32'h0, a}, {32'h0, waddr36});
    cmp("waddr8", {32'h0, a}, {32'h0, waddr8});
    @(posedge mclk);
    #1;
    cmp("busy36", 36'h0, {35'h0, busy36});
    cmp("busy8", 36'h0, {35'h0, busy8});
  endtask

  // -------------
  // Scenarios
  // -------------
  task automatic s_full();
    wr(4'h3, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0, 2'h0, 2'h0);
    wr(4'h4, 36'h0F0F0F0F0, 36'h3C3C3C3C3, 4'h0, 4'h0, 2'h0, 2'h0);
    rd_both(4'h3);
    rd_both(4'h4);
  endtask

  // Lane enables differ per beat in the first four passes, the last pass masks every lane of beat 0
  task automatic s_mask();
    logic [35:0] d;
    logic [3:0] b;
    logic [1:0] n;
    for (int l = 0; l < 5; l++)
    begin
      d = 36'h111111111 * 36'(l + 1);
      b = (l == 4) ? 4'hF : ~(4'h1 << l);
      n = (l == 4) ? 2'h3 : ~(2'h1 << (l % 2));
      wr(4'h3, d, ~d, b, {b[0], b[3:1]}, n, ~n);
      rd_both(4'h3);
    end
  endtask

  task automatic s_desel();
    int seen;
    seen = 0;
    ctl_u.burst(1'b1, 4'h3, 36'h0, 36'h0, 4'h0, 4'h0, 2'h0, 2'h0);
    repeat (12)
    begin
      @(posedge mclk);
      #1;
      if (done36 !== 1'b0 || done8 !== 1'b0)
        seen++;
    end
    cmp("desel_done", 36'h0, 36'(seen));
    rd_both(4'h3);
  endtask

  // A deselected K rise while K# is awaited drops the pending beat
  task automatic s_abort();
    int seen;
    seen = 0;
    ctl_u.cut_burst(4'h3, 36'h0);
    #1;
    cmp("abort_busy36", 36'h0, {35'h0, busy36});
    cmp("abort_busy8", 36'h0, {35'h0, busy8});
    repeat (6)
    begin
      @(posedge mclk);
      #1;
      if (done36 !== 1'b0 || done8 !== 1'b0)
        seen++;
    end
    cmp("abort_done", 36'h0, 36'(seen));
    rd_both(4'h3);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    rd_addr = 5'h00;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    s_full();
    s_mask();
    s_desel();
    s_abort();
    test_done();
  end
endmodule
